// file: inc/gpm_pkg.sv
// Purpose: Constants and types for the pin drive-select and input-gate block
// Assumes: 32-bit register bus, four ports of up to eight pins
// Notes:   Shared by the top, the port register and the pin cell modules
package gpm_pkg;

  localparam int NPORT = 4;
  localparam int NPIN  = 8;
  localparam int AW    = 12;

  localparam logic [3:0][AW-1:0] DS_OFS = {
    12'h0c0, 12'h080, 12'h040, 12'h000};
  localparam logic [3:0][AW-1:0] IG_OFS = {
    12'h0c4, 12'h084, 12'h044, 12'h004};

  localparam logic [3:0][15:0] DS_MASK = {
    16'h3ffc, 16'h03ff, 16'h03ff, 16'h0fff};
  localparam logic [3:0][7:0]  IG_MASK = {
    8'h7e, 8'h1f, 8'h1f, 8'h3f};

  localparam int IG_LSB       = 16;
  localparam int CFG_INIT_BIT = 10;

  localparam logic [15:0] DS_RST_QUASI = 16'hffff;
  localparam logic [15:0] DS_RST_INPUT = 16'h0000;
  localparam logic [7:0]  IG_RST       = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    GPM_INPUT,
    GPM_PUSH_PULL,
    GPM_OPEN_DRAIN,
    GPM_QUASI
  } gpm_mode_t;

  typedef struct packed {
    logic [7:0]  input_gate;
    logic [15:0] drive_select;
  } gpm_port_cfg_t;

  typedef struct packed {
    logic [7:0] din;
    logic [7:0] pull_up;
    logic [7:0] oe;
    logic [7:0] o;
  } gpm_pad_t;

endpackage

// file: rtl/gpm_pin_cell.sv
// Purpose: One pin: drive mode decode and digital input gate
// Assumes: Mode field comes from a register, output value from the pin_output_value input
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module gpm_pin_cell
  import gpm_pkg::*;
(
  input  wire logic [1:0] mode,
  input  wire logic       out_value,
  input  wire logic       level,
  input  wire logic       gate,
  output logic            drv_o,
  output logic            drv_oe,
  output logic            pull_up,
  output logic            din
);

  always_comb begin
    drv_o  = 1'b0;
    drv_oe  = 1'b0;
    pull_up = 1'b0;
    case (gpm_mode_t'(mode))
      GPM_PUSH_PULL: begin
        drv_o  = out_value;
        drv_oe = 1'b1;
      end
      GPM_OPEN_DRAIN: begin
        // Only ever pulls low
        drv_oe = ~out_value;
      end
      GPM_QUASI: begin
        drv_o  = out_value;
        drv_oe = 1'b1;
        pull_up = out_value;
      end
      default: begin
        drv_oe = 1'b0;
      end
    endcase
    din = level & ~gate;
  end

endmodule
`default_nettype wire

// file: rtl/gpm_port_regs.sv
// Purpose: Drive-select and input-gate registers of one port
// Assumes: Synchronous active-low reset, byte strobes from the bus
// Notes:   Masks keep unimplemented bits at zero
`timescale 1ns/1ps
`default_nettype none
module gpm_port_regs
  import gpm_pkg::*;
#(
  parameter logic [15:0] DSM = 16'hffff,
  parameter logic [7:0]  IGM = 8'hff
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        init_choice,
  input  wire logic        wr_ds,
  input  wire logic        wr_ig,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output gpm_port_cfg_t    cfg
);

  gpm_port_cfg_t st_ff;
  gpm_port_cfg_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!aresetn) begin
      nxt_st.drive_select = (init_choice ? DS_RST_INPUT : DS_RST_QUASI)
                            & DSM;
      nxt_st.input_gate   = IG_RST;
    end else begin
      if (wr_ds) begin
        if (wstrb[0]) nxt_st.drive_select[7:0]  = wdata[7:0] & DSM[7:0];
        if (wstrb[1]) nxt_st.drive_select[15:8] = wdata[15:8] & DSM[15:8];
      end
      if (wr_ig && wstrb[2]) begin
        nxt_st.input_gate = wdata[IG_LSB +: 8] & IGM;
      end
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  assign cfg = st_ff;

endmodule
`default_nettype wire

// file: rtl/gpm_top.sv
// Purpose: Pin drive mode and input gate block with AXI4-Lite slave
// Assumes: Single clock aclk, synchronous active-low aresetn
// Notes:   Unmapped addresses answer SLVERR and read zero
`timescale 1ns/1ps
`default_nettype none
module gpm_top
  import gpm_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [31:0]           user_config_word,
  input  wire logic [AW-1:0]         s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AW-1:0]         s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [3:0][7:0]       pin_level,
  input  wire logic [3:0][7:0]       pin_output_value,
  output gpm_port_cfg_t [NPORT-1:0]  port_cfg,
  output gpm_pad_t      [NPORT-1:0]  pad
);

  typedef struct packed {
    logic          aw_got;
    logic          w_got;
    logic [AW-1:0] waddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
  } gpm_bus_st_t;

  gpm_bus_st_t      st_ff;
  gpm_bus_st_t      nxt_st;
  logic             we;
  logic [NPORT-1:0] wr_ds;
  logic [NPORT-1:0] wr_ig;
  logic             wr_hit;
  logic             rd_hit;
  logic [31:0]      rd_data;
  logic             power_on_drive_choice;

  assign power_on_drive_choice = user_config_word[CFG_INIT_BIT];

  assign s_axi_awready = ~st_ff.aw_got & ~st_ff.bvalid;
  assign s_axi_wready  = ~st_ff.w_got & ~st_ff.bvalid;
  assign s_axi_arready = ~st_ff.rvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rresp   = st_ff.rresp;
  assign s_axi_rdata   = st_ff.rdata;

  assign we = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;

  // Write decode
  always_comb begin
    wr_ds  = '0;
    wr_ig  = '0;
    wr_hit = 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      if (st_ff.waddr == DS_OFS[p]) begin
        wr_ds[p] = we;
        wr_hit   = 1'b1;
      end else if (st_ff.waddr == IG_OFS[p]) begin
        wr_ig[p] = we;
        wr_hit   = 1'b1;
      end
    end
  end

  // Read decode, reserved bits stay zero
  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      if (s_axi_araddr == DS_OFS[p]) begin
        rd_data[15:0] = port_cfg[p].drive_select;
        rd_hit        = 1'b1;
      end else if (s_axi_araddr == IG_OFS[p]) begin
        rd_data[IG_LSB +: 8] = port_cfg[p].input_gate;
        rd_hit               = 1'b1;
      end
    end
  end

  always_comb begin
    nxt_st = st_ff;
    if (!aresetn) begin
      nxt_st = '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        nxt_st.aw_got = 1'b1;
        nxt_st.waddr  = {s_axi_awaddr[AW-1:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        nxt_st.w_got = 1'b1;
        nxt_st.wdata = s_axi_wdata;
        nxt_st.wstrb = s_axi_wstrb;
      end
      if (we) begin
        nxt_st.aw_got = 1'b0;
        nxt_st.w_got  = 1'b0;
        nxt_st.bvalid = 1'b1;
        nxt_st.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (st_ff.bvalid && s_axi_bready) begin
        nxt_st.bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        nxt_st.rvalid = 1'b1;
        nxt_st.rdata  = rd_data;
        nxt_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (st_ff.rvalid && s_axi_rready) begin
        nxt_st.rvalid = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  // Per-port registers and per-pin cells
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    gpm_port_regs #(
      .DSM (DS_MASK[p]),
      .IGM (IG_MASK[p])
    ) u_regs (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .init_choice (power_on_drive_choice),
      .wr_ds       (wr_ds[p]),
      .wr_ig       (wr_ig[p]),
      .wdata       (st_ff.wdata),
      .wstrb       (st_ff.wstrb),
      .cfg         (port_cfg[p])
    );
    for (genvar n = 0; n < NPIN; n++) begin : g_pin
      gpm_pin_cell u_pin (
        .mode      (port_cfg[p].drive_select[2*n +: 2]),
        .out_value (pin_output_value[p][n]),
        .level     (pin_level[p][n]),
        .gate      (port_cfg[p].input_gate[n]),
        .drv_o     (pad[p].o[n]),
        .drv_oe    (pad[p].oe[n]),
        .pull_up   (pad[p].pull_up[n]),
        .din       (pad[p].din[n])
      );
    end
  end

  // Checks on bus answers, registers and pin outputs
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  push_pull_drive_a: assert property (
    port_cfg[0].drive_select[1:0] == 2'h1
    |-> pad[0].oe[0] && pad[0].o[0] == pin_output_value[0][0])
    else $error("push-pull pin not driven from output value");

  input_no_drive_a: assert property (
    port_cfg[1].drive_select[7:6] == 2'h0 |-> !pad[1].oe[3])
    else $error("input-mode pin is driven");

  open_drain_low_a: assert property (
    port_cfg[2].drive_select[5:4] == 2'h2
    |-> !(pad[2].oe[2] && pad[2].o[2])
        && pad[2].oe[2] == !pin_output_value[2][2])
    else $error("open-drain pin drives high or fails to pull low");

  init_quasi_a: assert property (
    !$past(aresetn) && !$past(user_config_word[10])
    |-> port_cfg[0].drive_select == 16'h0fff
        && port_cfg[3].drive_select == 16'h3ffc)
    else $error("drive fields not quasi after reset");

  init_input_a: assert property (
    !$past(aresetn) && $past(user_config_word[10])
    |-> port_cfg[1].drive_select == 16'h0000)
    else $error("drive fields not input after reset");

  gate_reset_zero_a: assert property (
    !$past(aresetn) |-> port_cfg[2].input_gate == 8'h00)
    else $error("input gate not zero after reset");

  unimpl_reads_zero_a: assert property (
    port_cfg[3].drive_select[1:0] == 2'h0
    && port_cfg[3].input_gate[0] == 1'b0
    && port_cfg[0].drive_select[15:12] == 4'h0)
    else $error("unimplemented pin bits not zero");

  gate_forces_low_a: assert property (
    pad[1].din[3] == (pin_level[1][3] && !port_cfg[1].input_gate[3]))
    else $error("gated input path wrong");

  ds_readback_a: assert property (
    wr_ds[1] && st_ff.wstrb[1:0] == 2'h3
    |=> port_cfg[1].drive_select
        == ($past(st_ff.wdata[15:0]) & 16'h03ff))
    else $error("drive select did not take written value");

  gate_read_map_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h0c4
    |=> s_axi_rvalid && s_axi_rresp == 2'h0
        && s_axi_rdata[23:16] == $past(port_cfg[3].input_gate)
        && s_axi_rdata[15:0] == 16'h0000
        && s_axi_rdata[31:24] == 8'h00)
    else $error("input gate register read wrong");

  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after accept");

  // Read answer one cycle after accept; answers stand until taken
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not valid one cycle after accept");

  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed before it was taken");

  write_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer changed before it was taken");

  write_refuse_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");

  // Unmapped offsets: error answer, no effect
  bad_write_err_a: assert property (
    we && !wr_hit
    |=> s_axi_bvalid && s_axi_bresp == 2'h2 && $stable(port_cfg))
    else $error("unmapped write not refused or took effect");

  bad_read_zero_a: assert property (
    s_axi_arvalid && s_axi_arready && !rd_hit
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused or not zero");

  // Register contents change only on a landed write
  idle_no_change_a: assert property (
    !we |=> $stable(port_cfg))
    else $error("configuration changed without a write");

  ds_byte_keep_a: assert property (
    wr_ds[0] && !st_ff.wstrb[1]
    |=> port_cfg[0].drive_select[15:8]
        == $past(port_cfg[0].drive_select[15:8]))
    else $error("unstrobed drive byte was changed");

  gate_write_a: assert property (
    wr_ig[2] && st_ff.wstrb[2]
    |=> port_cfg[2].input_gate == ($past(st_ff.wdata[23:16]) & 8'h1f))
    else $error("input gate did not take written value");

  gate_keep_a: assert property (
    wr_ig[0] && !st_ff.wstrb[2] |=> $stable(port_cfg[0].input_gate))
    else $error("unstrobed input gate byte was changed");

  ds_read_map_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h040
    |=> s_axi_rvalid && s_axi_rresp == 2'h0
        && s_axi_rdata == {16'h0000, $past(port_cfg[1].drive_select)})
    else $error("drive select register read wrong");

  quasi_pullup_a: assert property (
    port_cfg[3].drive_select[13:12] == 2'h3
    |-> pad[3].oe[6] && pad[3].o[6] == pin_output_value[3][6]
        && pad[3].pull_up[6] == pin_output_value[3][6])
    else $error("quasi pin drive or pull-up wrong");

  // Main scenarios
  quasi_start_c: cover property (
    !$past(aresetn) && port_cfg[0].drive_select == 16'h0fff);
  open_drain_c: cover property (
    port_cfg[2].drive_select[5:4] == 2'h2 && pad[2].oe[2]);
  gate_on_c: cover property (
    port_cfg[1].input_gate[3] && pin_level[1][3]);
  bad_addr_c: cover property (
    s_axi_bvalid && s_axi_bresp == 2'h2);
  quasi_pull_c: cover property (
    pad[3].pull_up[6] && pad[3].oe[6]);

endmodule
`default_nettype wire

// file: test/tb.sv
// Purpose: Self-checking bench for the drive-select and input-gate block
// Assumes: AXI4-Lite master moving signals on rising edges, fixed seed
// Notes:   Expected values come from a register model kept in the bench
`timescale 1ns/1ps
`default_nettype none
module tb
  import gpm_pkg::*;
;
  logic                      aclk;
  logic                      aresetn;
  logic [31:0]               user_config_word;
  logic [AW-1:0]             s_axi_awaddr;
  logic                      s_axi_awvalid;
  logic                      s_axi_awready;
  logic [31:0]               s_axi_wdata;
  logic [3:0]                s_axi_wstrb;
  logic                      s_axi_wvalid;
  logic                      s_axi_wready;
  logic [1:0]                s_axi_bresp;
  logic                      s_axi_bvalid;
  logic                      s_axi_bready;
  logic [AW-1:0]             s_axi_araddr;
  logic                      s_axi_arvalid;
  logic                      s_axi_arready;
  logic [31:0]               s_axi_rdata;
  logic [1:0]                s_axi_rresp;
  logic                      s_axi_rvalid;
  logic                      s_axi_rready;
  logic [3:0][7:0]           pin_level;
  logic [3:0][7:0]           pin_output_value;
  gpm_port_cfg_t [NPORT-1:0] port_cfg;
  gpm_pad_t [NPORT-1:0]      pad;
  int                        num_errors;
  int                        check_count;
  logic [31:0]               mdl [8];

  gpm_top gpm_top_inst (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .user_config_word (user_config_word),
    .s_axi_awaddr     (s_axi_awaddr),
    .s_axi_awvalid    (s_axi_awvalid),
    .s_axi_awready    (s_axi_awready),
    .s_axi_wdata      (s_axi_wdata),
    .s_axi_wstrb      (s_axi_wstrb),
    .s_axi_wvalid     (s_axi_wvalid),
    .s_axi_wready     (s_axi_wready),
    .s_axi_bresp      (s_axi_bresp),
    .s_axi_bvalid     (s_axi_bvalid),
    .s_axi_bready     (s_axi_bready),
    .s_axi_araddr     (s_axi_araddr),
    .s_axi_arvalid    (s_axi_arvalid),
    .s_axi_arready    (s_axi_arready),
    .s_axi_rdata      (s_axi_rdata),
    .s_axi_rresp      (s_axi_rresp),
    .s_axi_rvalid     (s_axi_rvalid),
    .s_axi_rready     (s_axi_rready),
    .pin_level        (pin_level),
    .pin_output_value (pin_output_value),
    .port_cfg         (port_cfg),
    .pad              (pad)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic conclude();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [AW-1:0] adr(int r);
    return r[0] ? IG_OFS[r/2] : DS_OFS[r/2];
  endfunction

  function automatic logic [31:0] msk(int r);
    return r[0] ? {8'h00, IG_MASK[r/2], 16'h0000} : {16'h0000, DS_MASK[r/2]};
  endfunction

  function automatic logic [31:0] upd(logic [31:0] o, logic [31:0] d,
                                      logic [3:0] s, logic [31:0] k);
    for (int i = 0; i < 4; i++) if (s[i]) o[8*i+:8] = d[8*i+:8];
    return o & k;
  endfunction

  task automatic axw(input logic [AW-1:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] rs);
    logic aw_t, w_t, b_t;
    int   n;
    b_t = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_t && n < 50) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && (s_axi_awready === 1'b1);
      w_t = s_axi_wvalid && (s_axi_wready === 1'b1);
      b_t = (s_axi_bvalid === 1'b1);
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    chk({31'h0, b_t}, 32'h1);
  endtask

  task automatic axr(input logic [AW-1:0] a, output logic [31:0] d,
                     output logic [1:0] rs);
    logic ar_t, r_t;
    int   n;
    r_t = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_t && n < 50) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && (s_axi_arready === 1'b1);
      r_t = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    chk({31'h0, r_t}, 32'h1);
  endtask

  task automatic wr_chk(input int r, input logic [31:0] d,
                        input logic [3:0] s);
    logic [1:0] rs;
    axw(adr(r), d, s, rs);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    mdl[r] = upd(mdl[r], d, s, msk(r));
  endtask

  task automatic rd_chk(input int r);
    logic [31:0] d;
    logic [1:0]  rs;
    axr(adr(r), d, rs);
    chk(d, mdl[r]);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask

  task automatic do_reset(input logic choice);
    logic [31:0] cw;
    cw = $urandom;
    cw[CFG_INIT_BIT] = choice;
    aresetn <= 1'b0;
    user_config_word <= cw;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int r = 0; r < 8; r++) mdl[r] = (choice || r[0]) ? 32'h0 : msk(r);
  endtask

  task automatic chk_pads();
    logic [1:0] m;
    logic       v;
    logic [7:0] oe, hi, din, pu;
    @(posedge aclk);
    pin_level <= $urandom;
    pin_output_value <= $urandom;
    @(negedge aclk);
    for (int p = 0; p < NPORT; p++) begin
      for (int n = 0; n < NPIN; n++) begin
        m = mdl[2*p][2*n+:2];
        v = pin_output_value[p][n];
        oe[n] = (m == 2'h1) || (m == 2'h3) || (m == 2'h2 && !v);
        hi[n] = (m == 2'h1 || m == 2'h3) && v;
        pu[n] = (m == 2'h3) && v;
        din[n] = pin_level[p][n] & ~mdl[2*p+1][16+n];
      end
      chk({24'h0, pad[p].oe}, {24'h0, oe});
      chk({24'h0, pad[p].pull_up}, {24'h0, pu});
      chk({24'h0, pad[p].oe & pad[p].o}, {24'h0, hi});
      chk({24'h0, pad[p].din}, {24'h0, din});
      chk({8'h0, port_cfg[p]},
          {8'h0, mdl[2*p+1][23:16], mdl[2*p][15:0]});
    end
  endtask

  initial begin
    #80000;
    num_errors++;
    $display("[ERR] t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
    conclude();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  rs;
    aresetn = 1'b0;
    user_config_word = 32'h0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready, pin_level, pin_output_value} = '0;
    num_errors = 0;
    check_count = 0;
    d = $urandom(32'he994);
    do_reset(1'b0);
    for (int r = 0; r < 8; r++) rd_chk(r);
    chk_pads();
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 8; r += 2) wr_chk(r, {16{m[1:0]}}, 4'hf);
      wr_chk(1 + 2 * m, 32'hffffffff, 4'hf);
      chk_pads();
    end
    for (int i = 0; i < 40; i++) begin
      wr_chk($urandom_range(7, 0), $urandom,
             (i % 3 == 0) ? 4'($urandom) : 4'hf);
      chk_pads();
      rd_chk($urandom_range(7, 0));
    end
    axw(12'h008, 32'hffffffff, 4'hf, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    axr(12'h100, d, rs);
    chk(d, 32'h0);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    for (int r = 0; r < 8; r++) rd_chk(r);
    do_reset(1'b1);
    for (int r = 0; r < 8; r++) rd_chk(r);
    chk_pads();
    conclude();
  end
endmodule
`default_nettype wire
